// file: lcsd_pkg.sv
// Shared constants, types and decode helpers for the command decoder.
// Assumes a 100 MHz command clock; all timings derive from CLK_PS.
package lcsd_pkg;

  localparam int NUM_BANKS = 4;
  localparam int ROW_W = 14;
  localparam int COL_W = 10;
  localparam int KEY_W = 16;
  localparam int TMR_W = 4;
  localparam int CNT_W = 5;
  localparam int REF_ROW_W = 14;

  localparam int CLK_PS = 10000;
  localparam int T_RCD_NS = 15;
  localparam int T_RP_NS = 15;
  localparam int T_WR_NS = 12;
  localparam int T_RFC_NS = 120;
  // Least times: round up to whole clock cycles
  localparam int RCD_CYC = (T_RCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RP_CYC = (T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WR_CYC = (T_WR_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RFC_CYC = (T_RFC_NS * 1000 + CLK_PS - 1) / CLK_PS;

  localparam int AP_BIT = 10;
  localparam int BL_LSB = 0;
  localparam int BL_W = 3;
  localparam logic [1:0] SEL_BASE_MODE = 2'h0;
  localparam logic [1:0] SEL_EXT_MODE = 2'h2;
  localparam logic [KEY_W-1:0] MODE_KEY_RST = 16'h0000;
  localparam logic [KEY_W-1:0] EXT_KEY_RST = 16'h0000;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_ACT = 3'b001,
    CMD_RD = 3'b010,
    CMD_WR = 3'b011,
    CMD_BST = 3'b100,
    CMD_PRE = 3'b101,
    CMD_REF = 3'b110,
    CMD_MRS = 3'b111
  } lcsd_cmd_type;

  typedef enum logic [2:0] {
    BK_IDLE = 3'b000,
    BK_ACTIVATING = 3'b001,
    BK_ACTIVE = 3'b010,
    BK_READ = 3'b011,
    BK_WRITE = 3'b100,
    BK_WREC = 3'b101,
    BK_PRECH = 3'b110,
    BK_REFRESH = 3'b111
  } lcsd_bank_state_type;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_select_high;
    logic bank_select_low;
    logic [ROW_W-1:0] addr;
  } lcsd_cmd_pins_type;

  // Unassigned strobe patterns and deselect fall through to no operation
  function automatic lcsd_cmd_type lcsd_decode(lcsd_cmd_pins_type p);
    lcsd_cmd_type c;
    c = CMD_NOP;
    if (!p.cs_n) begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'b011: c = CMD_ACT;
        3'b101: c = CMD_RD;
        3'b100: c = CMD_WR;
        3'b110: c = CMD_BST;
        3'b010: c = CMD_PRE;
        3'b001: c = CMD_REF;
        3'b000: c = CMD_MRS;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction : lcsd_decode

  // Burst length code to clock cycles (two beats per cycle)
  function automatic logic [CNT_W-1:0] lcsd_bl_cycles(logic [BL_W-1:0] code);
    logic [CNT_W-1:0] n;
    case (code)
      3'h2: n = 5'h02;
      3'h3: n = 5'h04;
      3'h4: n = 5'h08;
      default: n = 5'h01;
    endcase
    return n;
  endfunction : lcsd_bl_cycles

endpackage : lcsd_pkg

// file: lcsd_sync.sv
// Three-stage synchroniser with agreement filter for a level.
// Assumes the source is quasi-static relative to the destination clock.
`timescale 1ns/1ns
module lcsd_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  wire [W-1:0] agree = ~(s2_q ^ s3_q);
  wire [W-1:0] out_d = (agree & s3_q) | (~agree & out_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule : lcsd_sync

// file: lcsd_wlink.sv
// Write data capture on both strobe edges with same-edge masking.
// Runs entirely on the strobe clock; write_open arrives synchronised.
`timescale 1ns/1ns
module lcsd_wlink #(
  parameter int DW = 32,
  parameter int MW = 4
) (
  input wire logic strobe_clk,
  input wire logic rst_n,
  input wire logic write_open,
  input wire logic [DW-1:0] wdata_in,
  input wire logic [MW-1:0] write_mask,
  output logic [DW-1:0] rise_word_q,
  output logic [MW-1:0] rise_keep_q,
  output logic [DW-1:0] fall_word_q,
  output logic [MW-1:0] fall_keep_q
);
  import lcsd_pkg::*;
  // Mask applies to the very beat it arrives with
  wire [MW-1:0] keep_d = write_open ? ~write_mask : '0;

  always_ff @(posedge strobe_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_word_q <= '0;
      rise_keep_q <= '0;
    end else begin
      rise_word_q <= wdata_in;
      rise_keep_q <= keep_d;
    end
  end

  always_ff @(negedge strobe_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_word_q <= '0;
      fall_keep_q <= '0;
    end else begin
      fall_word_q <= wdata_in;
      fall_keep_q <= keep_d;
    end
  end

  AST_RISE_MASK: assert property (@(posedge strobe_clk) disable iff (!rst_n)
    write_open |=> rise_keep_q == ~$past(write_mask))
    else $error("write mask not applied on rising strobe beat");
endmodule : lcsd_wlink

// file: lcsd_decoder.sv
// Command decoder and per-bank state tracker of a four-bank LP DDR die.
// Assumes command pins are launched on clk by the memory controller.
`timescale 1ns/1ns
module lcsd_decoder #(
  parameter int DW = 32,
  parameter int MW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire lcsd_pkg::lcsd_cmd_pins_type cmd_pins,
  input wire logic strobe_clk,
  input wire logic [DW-1:0] wdata_in,
  input wire logic [MW-1:0] write_mask,
  output lcsd_pkg::lcsd_bank_state_type [lcsd_pkg::NUM_BANKS-1:0] bank_state,
  output logic [lcsd_pkg::NUM_BANKS-1:0][lcsd_pkg::ROW_W-1:0] open_row,
  output logic [lcsd_pkg::KEY_W-1:0] mode_key,
  output logic [lcsd_pkg::KEY_W-1:0] ext_mode_key,
  output logic [1:0] burst_bank,
  output logic [lcsd_pkg::COL_W-1:0] burst_col,
  output logic [lcsd_pkg::CNT_W-1:0] burst_left,
  output logic [lcsd_pkg::REF_ROW_W-1:0] refresh_row,
  output logic cmd_taken,
  output logic cmd_illegal,
  output logic [DW-1:0] rise_word,
  output logic [MW-1:0] rise_keep,
  output logic [DW-1:0] fall_word,
  output logic [MW-1:0] fall_keep
);
  import lcsd_pkg::*;

  localparam int A_RCD = RCD_CYC;
  localparam int A_RFC = RFC_CYC;

  lcsd_bank_state_type [NUM_BANKS-1:0] st_q, st_d;
  logic [NUM_BANKS-1:0][TMR_W-1:0] tmr_q, tmr_d;
  logic [NUM_BANKS-1:0][ROW_W-1:0] row_q, row_d;
  logic [NUM_BANKS-1:0] ap_q, ap_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] bb_q, bb_d;
  logic [COL_W-1:0] col_q, col_d;
  logic [KEY_W-1:0] key_q, ext_key_q;
  logic [REF_ROW_W-1:0] ref_row_q;
  logic taken_q, illegal_q;
  logic write_open_q;
  logic write_open_link;

  // Decode
  wire lcsd_cmd_type cmd = lcsd_decode(cmd_pins);
  wire [1:0] tgt = {cmd_pins.bank_select_high, cmd_pins.bank_select_low};
  wire ap_flag = cmd_pins.addr[AP_BIT];
  wire lcsd_bank_state_type tst = st_q[tgt];
  wire bursting = cnt_q != '0;
  wire lcsd_bank_state_type bst = st_q[bb_q];
  wire burst_wr = bursting && bst == BK_WRITE;
  wire burst_rd = bursting && bst == BK_READ;
  wire wap_block = burst_wr && ap_q[bb_q];
  wire [CNT_W-1:0] bl = lcsd_bl_cycles(key_q[BL_LSB +: BL_W]);
  wire [KEY_W-1:0] key_in = {tgt, cmd_pins.addr};

  logic all_idle, pre_all_ok;
  always_comb begin
    all_idle = 1'b1;
    pre_all_ok = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (st_q[b] != BK_IDLE) all_idle = 1'b0;
      if (st_q[b] == BK_ACTIVATING || st_q[b] == BK_REFRESH ||
          st_q[b] == BK_WREC) pre_all_ok = 1'b0;
    end
  end

  wire tgt_open = tst == BK_ACTIVE || tst == BK_READ || tst == BK_WRITE;
  wire pre_one_ok = tst == BK_IDLE || tst == BK_PRECH ||
                    (tgt_open && !(tst != BK_ACTIVE && ap_q[tgt]));
  wire rd_ok = !wap_block && tgt_open && !(tst == BK_READ && ap_q[tgt]);
  wire wr_ok = !wap_block && !burst_rd &&
               (tst == BK_ACTIVE || tst == BK_WRITE || tst == BK_WREC);

  // Classify against the bank state table
  logic legal;
  always_comb begin
    case (cmd)
      CMD_NOP: legal = 1'b1;
      CMD_ACT: legal = tst == BK_IDLE;
      CMD_RD: legal = rd_ok;
      CMD_WR: legal = wr_ok;
      CMD_BST: legal = !bursting || (burst_rd && !ap_q[bb_q]);
      CMD_PRE: legal = ap_flag ? (pre_all_ok && !wap_block) : pre_one_ok;
      CMD_REF: legal = all_idle;
      CMD_MRS: legal = all_idle;
      default: legal = 1'b0;
    endcase
  end
  wire do_cmd = legal && cmd != CMD_NOP;
  wire mrs_base = do_cmd && cmd == CMD_MRS && tgt == SEL_BASE_MODE;
  wire mrs_ext = do_cmd && cmd == CMD_MRS && tgt == SEL_EXT_MODE;

  // Next bank states
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    row_d = row_q;
    ap_d = ap_q;
    bb_d = bb_q;
    col_d = col_q;
    cnt_d = bursting ? cnt_q - 5'h01 : cnt_q;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (tmr_q[b] != '0) begin
        tmr_d[b] = tmr_q[b] - 4'h1;
      end else begin
        case (st_q[b])
          BK_ACTIVATING: st_d[b] = BK_ACTIVE;
          BK_PRECH: st_d[b] = BK_IDLE;
          BK_REFRESH: st_d[b] = BK_IDLE;
          BK_WREC: begin
            st_d[b] = ap_q[b] ? BK_PRECH : BK_ACTIVE;
            tmr_d[b] = TMR_W'(RP_CYC - 1);
            ap_d[b] = 1'b0;
          end
          default: st_d[b] = st_q[b];
        endcase
      end
    end
    // Burst end by count, by a new access elsewhere, or by burst stop
    if ((cnt_q == 5'h01) || (bursting && do_cmd && cmd == CMD_BST) ||
        (bursting && do_cmd && (cmd == CMD_RD || cmd == CMD_WR) &&
         tgt != bb_q)) begin
      if (bst == BK_WRITE) begin
        st_d[bb_q] = BK_WREC;
        tmr_d[bb_q] = TMR_W'(WR_CYC - 1);
      end else if (bst == BK_READ) begin
        st_d[bb_q] = ap_q[bb_q] ? BK_PRECH : BK_ACTIVE;
        tmr_d[bb_q] = TMR_W'(RP_CYC - 1);
        ap_d[bb_q] = 1'b0;
      end
      cnt_d = '0;
    end
    if (do_cmd) begin
      case (cmd)
        CMD_ACT: begin
          st_d[tgt] = BK_ACTIVATING;
          tmr_d[tgt] = TMR_W'(RCD_CYC - 1);
          row_d[tgt] = cmd_pins.addr;
        end
        CMD_RD, CMD_WR: begin
          st_d[tgt] = cmd == CMD_RD ? BK_READ : BK_WRITE;
          tmr_d[tgt] = '0;
          ap_d[tgt] = ap_flag;
          cnt_d = bl;
          bb_d = tgt;
          col_d = cmd_pins.addr[COL_W-1:0];
        end
        CMD_PRE: begin
          for (int b = 0; b < NUM_BANKS; b++) begin
            if ((ap_flag || tgt == 2'(b)) && (st_q[b] == BK_ACTIVE ||
                st_q[b] == BK_READ || st_q[b] == BK_WRITE)) begin
              st_d[b] = BK_PRECH;
              tmr_d[b] = TMR_W'(RP_CYC - 1);
              ap_d[b] = 1'b0;
              if (bursting && bb_q == 2'(b)) cnt_d = '0;
            end
          end
        end
        CMD_REF: begin
          for (int b = 0; b < NUM_BANKS; b++) begin
            st_d[b] = BK_REFRESH;
            tmr_d[b] = TMR_W'(RFC_CYC - 1);
          end
        end
        default: st_d = st_d;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{default: BK_IDLE};
      tmr_q <= '0;
      row_q <= '0;
      ap_q <= '0;
      cnt_q <= '0;
      bb_q <= '0;
      col_q <= '0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      row_q <= row_d;
      ap_q <= ap_d;
      cnt_q <= cnt_d;
      bb_q <= bb_d;
      col_q <= col_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= MODE_KEY_RST;
      ext_key_q <= EXT_KEY_RST;
      ref_row_q <= '0;
      taken_q <= 1'b0;
      illegal_q <= 1'b0;
      write_open_q <= 1'b0;
    end else begin
      if (mrs_base) key_q <= key_in;
      if (mrs_ext) ext_key_q <= key_in;
      if (do_cmd && cmd == CMD_REF) ref_row_q <= ref_row_q + 14'h0001;
      taken_q <= do_cmd;
      illegal_q <= !legal;
      write_open_q <= st_d[bb_d] == BK_WRITE && cnt_d != '0;
    end
  end

  // Write window crosses into the strobe domain as a level
  lcsd_sync #(.W(1)) u_open_sync (
    .clk(strobe_clk),
    .rst_n(rst_n),
    .async_in(write_open_q),
    .sync_out(write_open_link)
  );

  lcsd_wlink #(.DW(DW), .MW(MW)) u_wlink (
    .strobe_clk(strobe_clk),
    .rst_n(rst_n),
    .write_open(write_open_link),
    .wdata_in(wdata_in),
    .write_mask(write_mask),
    .rise_word_q(rise_word),
    .rise_keep_q(rise_keep),
    .fall_word_q(fall_word),
    .fall_keep_q(fall_keep)
  );

  assign bank_state = st_q;
  assign open_row = row_q;
  assign mode_key = key_q;
  assign ext_mode_key = ext_key_q;
  assign burst_bank = bb_q;
  assign burst_col = col_q;
  assign burst_left = cnt_q;
  assign refresh_row = ref_row_q;
  assign cmd_taken = taken_q;
  assign cmd_illegal = illegal_q;

  AST_ACT_OPENS: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd == CMD_ACT && legal && tgt == 2'h0) |=>
    st_q[0] == BK_ACTIVATING && row_q[0] == $past(cmd_pins.addr)
    ##A_RCD st_q[0] == BK_ACTIVE)
    else $error("activate did not open bank 0 with its row");

  AST_RD_START: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd == CMD_RD && legal) |=> st_q[bb_q] == BK_READ &&
    cnt_q == $past(bl) && col_q == $past(cmd_pins.addr[COL_W-1:0]) &&
    ap_q[bb_q] == $past(ap_flag))
    else $error("read did not start burst with latched column");

  AST_WR_START: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd == CMD_WR && legal) |=> st_q[bb_q] == BK_WRITE &&
    bb_q == $past(tgt) && cnt_q == $past(bl))
    else $error("write did not start burst");

  AST_RD_CUTS_WR: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd == CMD_RD && legal && burst_wr && tgt != bb_q) |=>
    st_q[$past(bb_q)] == BK_WREC)
    else $error("read did not end the running write burst");

  AST_BST_STOPS: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd == CMD_BST && burst_rd) |=> cnt_q == '0 &&
    st_q[bb_q] == BK_ACTIVE)
    else $error("burst stop ignored");

  AST_PRE_ALL: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd == CMD_PRE && legal && ap_flag) |=>
    st_q[0] != BK_ACTIVE && st_q[1] != BK_ACTIVE &&
    st_q[2] != BK_ACTIVE && st_q[3] != BK_ACTIVE && cnt_q == '0)
    else $error("close all banks left a bank open");

  AST_NOP_KEEPS: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd == CMD_NOP && cnt_q > 5'h01) |=>
    cnt_q == $past(cnt_q) - 5'h01 && bb_q == $past(bb_q))
    else $error("no operation disturbed a burst");

  AST_REFRESH: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd == CMD_REF && legal) |=> st_q[2] == BK_REFRESH &&
    ref_row_q == $past(ref_row_q) + 14'h0001
    ##A_RFC st_q[2] == BK_IDLE)
    else $error("refresh did not run and close by itself");

  AST_MODE_KEY: assert property (@(posedge clk) disable iff (!rst_n)
    mrs_base |=> key_q == $past(key_in) && !taken_q == 1'b0)
    else $error("mode key not stored");

  AST_AUTOCLOSE: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_q == 5'h01 && bst == BK_READ && ap_q[bb_q] &&
     cmd == CMD_NOP) |=> st_q[$past(bb_q)] == BK_PRECH)
    else $error("read with autoclose did not precharge");
endmodule : lcsd_decoder

// file: lcsd_host_model.sv
// Memory controller model: encodes commands and drives write strobes.
// Assumes the bench calls its tasks; command pins move 1 ns after clk rises.
`timescale 1ns/1ns
module lcsd_host_model (
  input wire logic clk,
  output lcsd_pkg::lcsd_cmd_pins_type cmd_pins,
  output logic strobe_clk,
  output logic [31:0] wdata_in,
  output logic [3:0] write_mask
);
  import lcsd_pkg::*;

  initial begin
    cmd_pins = 20'h8_5555;
    strobe_clk = 1'b0;
    wdata_in = 32'h0000_0000;
    write_mask = 4'h0;
  end

  // One command for one clock, then deselect with scrambled pins
  task automatic issue(input lcsd_cmd_type c, input logic [1:0] bk,
                       input logic [13:0] a);
    logic [2:0] s;
    case (c)
      CMD_ACT: s = 3'b011;
      CMD_RD: s = 3'b101;
      CMD_WR: s = 3'b100;
      CMD_BST: s = 3'b110;
      CMD_PRE: s = 3'b010;
      CMD_REF: s = 3'b001;
      CMD_MRS: s = 3'b000;
      default: s = 3'b111;
    endcase
    @(posedge clk);
    #1;
    cmd_pins = {1'b0, s, bk, a};
    @(posedge clk);
    #1;
    cmd_pins = {1'b1, ~cmd_pins[18:0]};
  endtask : issue

  // Masks every remaining byte of a write that gets cut short
  task automatic mask_all();
    write_mask = 4'hF;
  endtask : mask_all

  // Strobe runs only inside a frame; mask and data change every edge
  task automatic frame(input int n);
    for (int k = 0; k < n; k++) begin
      #3;
      write_mask = 4'(k);
      wdata_in = {8{4'(k)}};
      #3;
      strobe_clk = 1'b1;
      #3;
      write_mask = ~4'(k);
      wdata_in = ~{8{4'(k)}};
      #3;
      strobe_clk = 1'b0;
    end
    // Hold past the last falling edge so that beat is captured intact
    #2;
    wdata_in = ~wdata_in;
    write_mask = ~write_mask;
  endtask : frame
endmodule : lcsd_host_model

// file: testbench.sv
// Self-checking bench for the command decoder and bank state tracker.
// Assumes the host model drives every command and data pin.
`timescale 1ns/1ns
module testbench;
  import lcsd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  lcsd_cmd_pins_type cmd_pins;
  logic strobe_clk;
  logic [31:0] wdata_in;
  logic [3:0] write_mask;
  lcsd_bank_state_type [NUM_BANKS-1:0] bank_state;
  logic [NUM_BANKS-1:0][ROW_W-1:0] open_row;
  logic [KEY_W-1:0] mode_key;
  logic [KEY_W-1:0] ext_mode_key;
  logic [1:0] burst_bank;
  logic [COL_W-1:0] burst_col;
  logic [CNT_W-1:0] burst_left;
  logic [REF_ROW_W-1:0] refresh_row;
  logic cmd_taken;
  logic cmd_illegal;
  logic [31:0] rise_word;
  logic [3:0] rise_keep;
  logic [31:0] fall_word;
  logic [3:0] fall_keep;
  int mismatches = 0;
  int tests_run = 0;
  lcsd_cmd_type bad[3] = '{CMD_ACT, CMD_REF, CMD_MRS};

  always #5 clk = ~clk;

  lcsd_host_model i_lcsd_host_model (.clk(clk), .cmd_pins(cmd_pins),
    .strobe_clk(strobe_clk), .wdata_in(wdata_in),
    .write_mask(write_mask));

  lcsd_decoder i_lcsd_decoder (.clk(clk), .rst_n(rst_n),
    .cmd_pins(cmd_pins), .strobe_clk(strobe_clk), .wdata_in(wdata_in),
    .write_mask(write_mask), .bank_state(bank_state),
    .open_row(open_row), .mode_key(mode_key),
    .ext_mode_key(ext_mode_key), .burst_bank(burst_bank),
    .burst_col(burst_col), .burst_left(burst_left),
    .refresh_row(refresh_row), .cmd_taken(cmd_taken),
    .cmd_illegal(cmd_illegal), .rise_word(rise_word),
    .rise_keep(rise_keep), .fall_word(fall_word),
    .fall_keep(fall_keep));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic st(input int b, input lcsd_bank_state_type e);
    check("bank_state", bank_state[b], e);
  endtask : st

  task automatic all(input lcsd_bank_state_type e);
    for (int b = 0; b < NUM_BANKS; b++) st(b, e);
  endtask : all

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic op(input lcsd_cmd_type c, input logic [1:0] bk,
                    input logic [13:0] a);
    i_lcsd_host_model.issue(c, bk, a);
  endtask : op

  // Keep must follow the mask of the same strobe edge once settled
  task automatic watch(input bit open);
    for (int k = 0; k < 7; k++) begin
      @(posedge strobe_clk);
      #1;
      if (k >= 4) begin
        check("rise_keep", rise_keep, open ? 4'(~k) : 4'h0);
        if (open) check("rise_word", rise_word, {8{4'(k)}});
      end
      @(negedge strobe_clk);
      #1;
      if (k >= 4) check("fall_keep", fall_keep, open ? 4'(k) : 4'h0);
      if (k >= 4 && open) check("fall_word", fall_word, ~{8{4'(k)}});
    end
  endtask : watch

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  initial begin
    #20000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    all(BK_IDLE);
    check("mode_key", mode_key, 16'h0000);
    check("refresh_row", refresh_row, 14'h0000);
    #1 rst_n = 1'b1;
    op(CMD_MRS, 2'b00, 14'h0004);
    check("mode_key", mode_key, 16'h0004);
    cyc(1);
    op(CMD_MRS, 2'b10, 14'h2A5C);
    check("ext_mode_key", ext_mode_key, 16'hAA5C);
    check("mode_key", mode_key, 16'h0004);
    cyc(1);
    op(CMD_REF, 2'b00, 14'h0000);
    all(BK_REFRESH);
    check("refresh_row", refresh_row, 14'h0001);
    cyc(13);
    all(BK_IDLE);
    op(CMD_ACT, 2'b01, 14'h1234);
    st(1, BK_ACTIVATING);
    cyc(2);
    st(1, BK_ACTIVE);
    check("open_row", open_row[1], 14'h1234);
    foreach (bad[i]) begin
      op(bad[i], 2'b01, 14'h0000);
      check("cmd_illegal", cmd_illegal, 1'b1);
      st(1, BK_ACTIVE);
    end
    check("mode_key", mode_key, 16'h0004);
    op(CMD_RD, 2'b01, 14'h0155);
    st(1, BK_READ);
    check("burst_left", burst_left, 5'h08);
    check("burst_col", burst_col, 10'h155);
    check("burst_bank", burst_bank, 2'h1);
    cyc(1);
    check("burst_left", burst_left, 5'h07);
    op(CMD_NOP, 2'b11, 14'h3FFF);
    check("burst_left", burst_left, 5'h05);
    check("cmd_taken", cmd_taken, 1'b0);
    op(CMD_RD, 2'b01, 14'h00AA);
    check("burst_col", burst_col, 10'h0AA);
    check("burst_left", burst_left, 5'h08);
    op(CMD_BST, 2'b01, 14'h0000);
    check("burst_left", burst_left, 5'h00);
    st(1, BK_ACTIVE);
    op(CMD_WR, 2'b01, 14'h0011);
    st(1, BK_WRITE);
    check("burst_col", burst_col, 10'h011);
    op(CMD_WR, 2'b01, 14'h0022);
    check("burst_col", burst_col, 10'h022);
    check("burst_left", burst_left, 5'h08);
    fork
      i_lcsd_host_model.frame(8);
      watch(1'b1);
    join
    cyc(4);
    op(CMD_WR, 2'b01, 14'h0033);
    i_lcsd_host_model.mask_all();
    op(CMD_RD, 2'b01, 14'h0044);
    check("cmd_taken", cmd_taken, 1'b1);
    check("burst_col", burst_col, 10'h044);
    op(CMD_BST, 2'b01, 14'h0000);
    cyc(6);
    op(CMD_WR, 2'b01, 14'h0055);
    op(CMD_PRE, 2'b01, 14'h0000);
    st(1, BK_PRECH);
    check("burst_left", burst_left, 5'h00);
    cyc(2);
    st(1, BK_IDLE);
    op(CMD_ACT, 2'b00, 14'h0001);
    op(CMD_ACT, 2'b10, 14'h0002);
    cyc(2);
    op(CMD_PRE, 2'b01, 14'h0400);
    st(0, BK_PRECH);
    st(2, BK_PRECH);
    st(3, BK_IDLE);
    cyc(2);
    all(BK_IDLE);
    op(CMD_ACT, 2'b11, 14'h3FFF);
    cyc(2);
    op(CMD_RD, 2'b11, 14'h07FF);
    check("burst_col", burst_col, 10'h3FF);
    cyc(8);
    st(3, BK_PRECH);
    cyc(2);
    st(3, BK_IDLE);
    op(CMD_ACT, 2'b11, 14'h0003);
    op(CMD_ACT, 2'b00, 14'h0004);
    cyc(2);
    op(CMD_WR, 2'b11, 14'h0400);
    op(CMD_RD, 2'b00, 14'h0000);
    check("cmd_illegal", cmd_illegal, 1'b1);
    cyc(6);
    op(CMD_RD, 2'b00, 14'h0000);
    check("cmd_taken", cmd_taken, 1'b1);
    cyc(3);
    st(3, BK_IDLE);
    op(CMD_ACT, 2'b11, 14'h0005);
    check("cmd_taken", cmd_taken, 1'b1);
    fork
      i_lcsd_host_model.frame(8);
      watch(1'b0);
    join
    op(CMD_WR, 2'b00, 14'h0066);
    check("cmd_illegal", cmd_illegal, 1'b0);
    i_lcsd_host_model.mask_all();
    op(CMD_RD, 2'b11, 14'h0077);
    st(0, BK_WREC);
    st(3, BK_READ);
    check("burst_bank", burst_bank, 2'h3);
    stop_test();
  end
endmodule : testbench
